// >>> bwmid_pkg.sv
// Constants, field layout and encodings of the bandwidth feature identification bank
// Functional notes
// - Absent register reads zero, writes ignored
// - Portion bitmap width 1..4096 in [28:16]
// - Bit 14 flags per-partition writable window
// - Bit 13 set only with stride control
// - Bit 12 set only with portion control
// - Bit 11 set only with max control
// - Bit 10 set only with min control
// - Bits [5:0] give allocation width 1..16
// - Registers read-only, readable from both pages
// - Differing page contents use separate instances
// - Both secure and non-secure pages provided
// - Decode at 0x0040, 0x0080 and 0x0090 per page
// - Usage bit 31 flags snapshot register present
// - Usage [20:16] scale shift, zero means none
// - Usage [15:0] give monitor count
// - Monitoring bit 31 flags local trigger
// - Monitoring bit 17 flags bandwidth usage monitors
// - Monitoring bit 16 flags cache usage monitors
package bwmid_pkg;

  // Byte offsets inside one feature page
  localparam logic [11:0] BWMID_OFF_BW_PART = 12'h040;
  localparam logic [11:0] BWMID_OFF_MON_FEAT = 12'h080;
  localparam logic [11:0] BWMID_OFF_BWU_MON = 12'h090;

  // Bus widths
  localparam int BWMID_ADDR_W = 12;
  localparam int BWMID_DATA_W = 32;

  // Bandwidth partition word fields
  localparam int BWMID_POS_PBM_WIDTH = 16;
  localparam int BWMID_W_PBM_WIDTH = 13;
  localparam int BWMID_POS_WIN_WR = 14;
  localparam int BWMID_POS_STRIDE = 13;
  localparam int BWMID_POS_PORTION = 12;
  localparam int BWMID_POS_MAX = 11;
  localparam int BWMID_POS_MIN = 10;
  localparam int BWMID_POS_ALLOC = 0;
  localparam int BWMID_W_ALLOC = 6;

  // Bandwidth usage monitor word fields
  localparam int BWMID_POS_SNAPSHOT = 31;
  localparam int BWMID_POS_SCALE = 16;
  localparam int BWMID_W_SCALE = 5;
  localparam int BWMID_POS_COUNT = 0;
  localparam int BWMID_W_COUNT = 16;

  // Monitoring feature word fields
  localparam int BWMID_POS_LOCAL_TRIG = 31;
  localparam int BWMID_POS_BWU_MON = 17;
  localparam int BWMID_POS_CACHE_MON = 16;

  // Reserved bit masks of each word
  localparam logic [31:0] BWMID_RSVD_BW_PART = 32'he000_83c0;
  localparam logic [31:0] BWMID_RSVD_BWU_MON = 32'h7fe0_0000;
  localparam logic [31:0] BWMID_RSVD_MON_FEAT = 32'h7ffc_ffff;

  // Legal field ranges
  localparam logic [12:0] BWMID_PBM_WIDTH_MIN = 13'h0001;
  localparam logic [12:0] BWMID_PBM_WIDTH_MAX = 13'h1000;
  localparam logic [5:0] BWMID_ALLOC_MIN = 6'h01;
  localparam logic [5:0] BWMID_ALLOC_MAX = 6'h10;

  // Reset value of read data
  localparam logic [31:0] BWMID_RDATA_RST = 32'h0000_0000;

  // Register selected by an address
  typedef enum logic [1:0] {
    BWMID_SEL_NONE = 2'h0,
    BWMID_SEL_BW_PART = 2'h1,
    BWMID_SEL_MON_FEAT = 2'h2,
    BWMID_SEL_BWU_MON = 2'h3
  } bwmid_sel_e;

  // Access sequencer states
  typedef enum logic [1:0] {
    BWMID_ST_IDLE = 2'b01,
    BWMID_ST_RESP = 2'b10
  } bwmid_state_e;

endpackage

// >>> bwmid_page_regs.sv
// Builds the three identification words of one feature page from build-time values
`timescale 1ns/1ps
module bwmid_page_regs #(
  parameter bit BW_PART_PRESENT = 1'b1,
  parameter bit MON_PRESENT = 1'b1,
  parameter logic [12:0] PBM_WIDTH = 13'h0020,
  parameter bit WIN_WRITABLE = 1'b0,
  parameter bit STRIDE_PRESENT = 1'b1,
  parameter bit PORTION_PRESENT = 1'b1,
  parameter bit MAX_PRESENT = 1'b1,
  parameter bit MIN_PRESENT = 1'b1,
  parameter logic [5:0] ALLOC_WIDTH = 6'h08,
  parameter bit SNAPSHOT_PRESENT = 1'b1,
  parameter logic [4:0] SCALE = 5'h00,
  parameter logic [15:0] MON_COUNT = 16'h0004,
  parameter bit LOCAL_TRIG_PRESENT = 1'b1,
  parameter bit BWU_MON_PRESENT = 1'b1,
  parameter bit CACHE_MON_PRESENT = 1'b0
) (
  // Page contents
  output wire logic [31:0] bw_part_word_o,
  output wire logic [31:0] mon_feat_word_o,
  output wire logic [31:0] bwu_mon_word_o
);

  // Raw words, reserved positions left at zero
  logic [31:0] bw_raw;
  logic [31:0] mon_raw;
  logic [31:0] bwu_raw;

  // Bandwidth partition word
  always_comb begin
    bw_raw = '0;
    bw_raw[bwmid_pkg::BWMID_POS_PBM_WIDTH +: bwmid_pkg::BWMID_W_PBM_WIDTH] = PBM_WIDTH;
    bw_raw[bwmid_pkg::BWMID_POS_WIN_WR] = WIN_WRITABLE;
    bw_raw[bwmid_pkg::BWMID_POS_STRIDE] = STRIDE_PRESENT;
    bw_raw[bwmid_pkg::BWMID_POS_PORTION] = PORTION_PRESENT;
    bw_raw[bwmid_pkg::BWMID_POS_MAX] = MAX_PRESENT;
    bw_raw[bwmid_pkg::BWMID_POS_MIN] = MIN_PRESENT;
    bw_raw[bwmid_pkg::BWMID_POS_ALLOC +: bwmid_pkg::BWMID_W_ALLOC] = ALLOC_WIDTH;
  end

  // Monitoring feature word
  always_comb begin
    mon_raw = '0;
    mon_raw[bwmid_pkg::BWMID_POS_LOCAL_TRIG] = LOCAL_TRIG_PRESENT;
    mon_raw[bwmid_pkg::BWMID_POS_BWU_MON] = BWU_MON_PRESENT;
    mon_raw[bwmid_pkg::BWMID_POS_CACHE_MON] = CACHE_MON_PRESENT;
  end

  // Bandwidth usage monitor word
  always_comb begin
    bwu_raw = '0;
    bwu_raw[bwmid_pkg::BWMID_POS_SNAPSHOT] = SNAPSHOT_PRESENT;
    bwu_raw[bwmid_pkg::BWMID_POS_SCALE +: bwmid_pkg::BWMID_W_SCALE] = SCALE;
    bwu_raw[bwmid_pkg::BWMID_POS_COUNT +: bwmid_pkg::BWMID_W_COUNT] = MON_COUNT;
  end

  // Absent registers read as zero
  assign bw_part_word_o = BW_PART_PRESENT ? bw_raw : '0;
  assign mon_feat_word_o = MON_PRESENT ? mon_raw : '0;
  assign bwu_mon_word_o = (MON_PRESENT && BWU_MON_PRESENT) ? bwu_raw : '0;

endmodule

// >>> bwmid_page_select.sv
// Picks the word of the addressed register on the addressed page
`timescale 1ns/1ps
module bwmid_page_select (
  // Selection
  input wire logic ns_i,
  input wire bwmid_pkg::bwmid_sel_e sel_i,
  // Secure page words
  input wire logic [31:0] s_bw_part_i,
  input wire logic [31:0] s_mon_feat_i,
  input wire logic [31:0] s_bwu_mon_i,
  // Non-secure page words
  input wire logic [31:0] ns_bw_part_i,
  input wire logic [31:0] ns_mon_feat_i,
  input wire logic [31:0] ns_bwu_mon_i,
  // Selected word
  output logic [31:0] word_o
);

  // Register then page select, unmapped reads zero
  always_comb begin
    word_o = '0;
    unique case (sel_i)
      bwmid_pkg::BWMID_SEL_BW_PART: word_o = ns_i ? ns_bw_part_i : s_bw_part_i;
      bwmid_pkg::BWMID_SEL_MON_FEAT: word_o = ns_i ? ns_mon_feat_i : s_mon_feat_i;
      bwmid_pkg::BWMID_SEL_BWU_MON: word_o = ns_i ? ns_bwu_mon_i : s_bwu_mon_i;
      bwmid_pkg::BWMID_SEL_NONE: word_o = '0;
    endcase
  end

endmodule

// >>> bwmid_feature_bank.sv
// Top of the bandwidth feature identification bank: access port, sequencer, both pages
`timescale 1ns/1ps
module bwmid_feature_bank #(
  // Secure page contents
  parameter bit S_BW_PART_PRESENT = 1'b1,
  parameter bit S_MON_PRESENT = 1'b1,
  parameter logic [12:0] S_PBM_WIDTH = 13'h0020,
  parameter bit S_WIN_WRITABLE = 1'b0,
  parameter bit S_STRIDE_PRESENT = 1'b1,
  parameter bit S_PORTION_PRESENT = 1'b1,
  parameter bit S_MAX_PRESENT = 1'b1,
  parameter bit S_MIN_PRESENT = 1'b1,
  parameter logic [5:0] S_ALLOC_WIDTH = 6'h08,
  parameter bit S_SNAPSHOT_PRESENT = 1'b1,
  parameter logic [4:0] S_SCALE = 5'h00,
  parameter logic [15:0] S_MON_COUNT = 16'h0004,
  parameter bit S_LOCAL_TRIG_PRESENT = 1'b1,
  parameter bit S_BWU_MON_PRESENT = 1'b1,
  parameter bit S_CACHE_MON_PRESENT = 1'b0,
  // Non-secure page contents
  parameter bit NS_BW_PART_PRESENT = 1'b1,
  parameter bit NS_MON_PRESENT = 1'b1,
  parameter logic [12:0] NS_PBM_WIDTH = 13'h0020,
  parameter bit NS_WIN_WRITABLE = 1'b0,
  parameter bit NS_STRIDE_PRESENT = 1'b1,
  parameter bit NS_PORTION_PRESENT = 1'b1,
  parameter bit NS_MAX_PRESENT = 1'b1,
  parameter bit NS_MIN_PRESENT = 1'b1,
  parameter logic [5:0] NS_ALLOC_WIDTH = 6'h08,
  parameter bit NS_SNAPSHOT_PRESENT = 1'b1,
  parameter logic [4:0] NS_SCALE = 5'h00,
  parameter logic [15:0] NS_MON_COUNT = 16'h0004,
  parameter bit NS_LOCAL_TRIG_PRESENT = 1'b1,
  parameter bit NS_BWU_MON_PRESENT = 1'b1,
  parameter bit NS_CACHE_MON_PRESENT = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Feature page access request
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic ns_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  // Access answer
  output wire logic ack_o,
  output wire logic [31:0] rdata_o,
  output wire logic wr_ignored_o
);

  // Address decode, word aligned byte offsets within a page
  function automatic bwmid_pkg::bwmid_sel_e decode_sel(input logic [11:0] addr);
    bwmid_pkg::bwmid_sel_e sel;
    sel = bwmid_pkg::BWMID_SEL_NONE;
    if (addr == bwmid_pkg::BWMID_OFF_BW_PART) begin
      sel = bwmid_pkg::BWMID_SEL_BW_PART;
    end else if (addr == bwmid_pkg::BWMID_OFF_MON_FEAT) begin
      sel = bwmid_pkg::BWMID_SEL_MON_FEAT;
    end else if (addr == bwmid_pkg::BWMID_OFF_BWU_MON) begin
      sel = bwmid_pkg::BWMID_SEL_BWU_MON;
    end
    return sel;
  endfunction

  // Secure page words
  logic [31:0] s_bw_part;
  logic [31:0] s_mon_feat;
  logic [31:0] s_bwu_mon;
  // Non-secure page words
  logic [31:0] ns_bw_part;
  logic [31:0] ns_mon_feat;
  logic [31:0] ns_bwu_mon;
  // Word picked by the current request
  logic [31:0] sel_word;
  bwmid_pkg::bwmid_sel_e req_sel;
  // Sequencer state and registered outputs
  bwmid_pkg::bwmid_state_e state;
  bwmid_pkg::bwmid_state_e next_state;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic wr_ignored;
  logic next_wr_ignored;
  // Request accepted this cycle
  logic take;
  // Write data is accepted but never stored
  logic [31:0] wdata_unused;

  assign wdata_unused = wdata_i;
  assign req_sel = decode_sel(addr_i);
  assign take = req_i && (state == bwmid_pkg::BWMID_ST_IDLE);

  // Secure page instance
  bwmid_page_regs #(
    .BW_PART_PRESENT(S_BW_PART_PRESENT),
    .MON_PRESENT(S_MON_PRESENT),
    .PBM_WIDTH(S_PBM_WIDTH),
    .WIN_WRITABLE(S_WIN_WRITABLE),
    .STRIDE_PRESENT(S_STRIDE_PRESENT),
    .PORTION_PRESENT(S_PORTION_PRESENT),
    .MAX_PRESENT(S_MAX_PRESENT),
    .MIN_PRESENT(S_MIN_PRESENT),
    .ALLOC_WIDTH(S_ALLOC_WIDTH),
    .SNAPSHOT_PRESENT(S_SNAPSHOT_PRESENT),
    .SCALE(S_SCALE),
    .MON_COUNT(S_MON_COUNT),
    .LOCAL_TRIG_PRESENT(S_LOCAL_TRIG_PRESENT),
    .BWU_MON_PRESENT(S_BWU_MON_PRESENT),
    .CACHE_MON_PRESENT(S_CACHE_MON_PRESENT)
  ) u_secure_page (
    .bw_part_word_o(s_bw_part),
    .mon_feat_word_o(s_mon_feat),
    .bwu_mon_word_o(s_bwu_mon)
  );

  // Non-secure page instance, kept separate so contents may differ
  bwmid_page_regs #(
    .BW_PART_PRESENT(NS_BW_PART_PRESENT),
    .MON_PRESENT(NS_MON_PRESENT),
    .PBM_WIDTH(NS_PBM_WIDTH),
    .WIN_WRITABLE(NS_WIN_WRITABLE),
    .STRIDE_PRESENT(NS_STRIDE_PRESENT),
    .PORTION_PRESENT(NS_PORTION_PRESENT),
    .MAX_PRESENT(NS_MAX_PRESENT),
    .MIN_PRESENT(NS_MIN_PRESENT),
    .ALLOC_WIDTH(NS_ALLOC_WIDTH),
    .SNAPSHOT_PRESENT(NS_SNAPSHOT_PRESENT),
    .SCALE(NS_SCALE),
    .MON_COUNT(NS_MON_COUNT),
    .LOCAL_TRIG_PRESENT(NS_LOCAL_TRIG_PRESENT),
    .BWU_MON_PRESENT(NS_BWU_MON_PRESENT),
    .CACHE_MON_PRESENT(NS_CACHE_MON_PRESENT)
  ) u_nonsecure_page (
    .bw_part_word_o(ns_bw_part),
    .mon_feat_word_o(ns_mon_feat),
    .bwu_mon_word_o(ns_bwu_mon)
  );

  // Page and register multiplexer
  bwmid_page_select u_select (
    .ns_i(ns_i),
    .sel_i(req_sel),
    .s_bw_part_i(s_bw_part),
    .s_mon_feat_i(s_mon_feat),
    .s_bwu_mon_i(s_bwu_mon),
    .ns_bw_part_i(ns_bw_part),
    .ns_mon_feat_i(ns_mon_feat),
    .ns_bwu_mon_i(ns_bwu_mon),
    .word_o(sel_word)
  );

  // Sequencer next state: one answer cycle per accepted request
  always_comb begin
    next_state = state;
    unique case (state)
      bwmid_pkg::BWMID_ST_IDLE: begin
        if (req_i) begin
          next_state = bwmid_pkg::BWMID_ST_RESP;
        end
      end
      bwmid_pkg::BWMID_ST_RESP: begin
        // Requests here are dropped
        next_state = bwmid_pkg::BWMID_ST_IDLE;
      end
      default: begin
        next_state = bwmid_pkg::BWMID_ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= bwmid_pkg::BWMID_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Answer next values: reads return the word, writes return zero and store nothing
  always_comb begin
    next_ack = take;
    next_wr_ignored = take && wr_i;
    if (take && !wr_i) begin
      next_rdata = sel_word;
    end else begin
      next_rdata = bwmid_pkg::BWMID_RDATA_RST;
    end
  end

  // Answer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= bwmid_pkg::BWMID_RDATA_RST;
      wr_ignored <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      wr_ignored <= next_wr_ignored;
    end
  end

  // Outputs straight from flip-flops
  assign ack_o = ack;
  assign rdata_o = rdata;
  assign wr_ignored_o = wr_ignored;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Accepted read of a given register on a given page
  sequence s_read(logic ns, bwmid_pkg::bwmid_sel_e sel);
    take && !wr_i && (ns_i == ns) && (decode_sel(addr_i) == sel);
  endsequence

  // One-cycle answer pulse
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence

  AST_ACK_PULSE: assert property (take |=> s_answer)
    else $error("answer not a single pulse one cycle after request");

  AST_REFUSED_IN_RESP: assert property ((state == bwmid_pkg::BWMID_ST_RESP) && req_i |=> !ack_o)
    else $error("request during answer cycle was not ignored");

  AST_WRITE_IGNORED: assert property (take && wr_i |=> ack_o && wr_ignored_o && (rdata_o == 32'h0) ##1 !wr_ignored_o)
    else $error("write not ignored");

  AST_S_BW_READ: assert property (s_read(1'b0, bwmid_pkg::BWMID_SEL_BW_PART) |=> rdata_o == s_bw_part)
    else $error("secure bandwidth partition read wrong");

  AST_NS_BWU_READ: assert property (s_read(1'b1, bwmid_pkg::BWMID_SEL_BWU_MON) |=> rdata_o == ns_bwu_mon)
    else $error("non-secure usage monitor read wrong");

  AST_NS_MON_READ: assert property (s_read(1'b1, bwmid_pkg::BWMID_SEL_MON_FEAT) |=> rdata_o == ns_mon_feat)
    else $error("non-secure monitoring read wrong");

  AST_UNMAPPED_ZERO: assert property (s_read(1'b0, bwmid_pkg::BWMID_SEL_NONE) |=> ack_o && (rdata_o == 32'h0))
    else $error("unmapped read not zero");

  AST_BWU_GATED: assert property (!s_mon_feat[bwmid_pkg::BWMID_POS_BWU_MON] |-> s_bwu_mon == 32'h0)
    else $error("usage monitor word visible while absent");

  AST_PBM_RANGE: assert property (s_bw_part != 32'h0 |->
    (s_bw_part[28:16] >= bwmid_pkg::BWMID_PBM_WIDTH_MIN) && (s_bw_part[28:16] <= bwmid_pkg::BWMID_PBM_WIDTH_MAX))
    else $error("portion bitmap width out of range");

  AST_ALLOC_RANGE: assert property (ns_bw_part != 32'h0 |->
    (ns_bw_part[5:0] >= bwmid_pkg::BWMID_ALLOC_MIN) && (ns_bw_part[5:0] <= bwmid_pkg::BWMID_ALLOC_MAX))
    else $error("allocation field width out of range");

  AST_RESERVED_ZERO: assert property (((s_bw_part | ns_bw_part) & bwmid_pkg::BWMID_RSVD_BW_PART) == 32'h0
    && ((s_bwu_mon | ns_bwu_mon) & bwmid_pkg::BWMID_RSVD_BWU_MON) == 32'h0
    && ((s_mon_feat | ns_mon_feat) & bwmid_pkg::BWMID_RSVD_MON_FEAT) == 32'h0)
    else $error("reserved bit set");

  // Every field on each page sits where the register layout puts it
  AST_S_PART_FIELDS: assert property (s_bw_part == (S_BW_PART_PRESENT ?
    {3'h0, S_PBM_WIDTH, 1'b0, S_WIN_WRITABLE, S_STRIDE_PRESENT, S_PORTION_PRESENT,
    S_MAX_PRESENT, S_MIN_PRESENT, 4'h0, S_ALLOC_WIDTH} : 32'h0))
    else $error("secure bandwidth partition fields misplaced");

  AST_NS_PART_FIELDS: assert property (ns_bw_part == (NS_BW_PART_PRESENT ?
    {3'h0, NS_PBM_WIDTH, 1'b0, NS_WIN_WRITABLE, NS_STRIDE_PRESENT, NS_PORTION_PRESENT,
    NS_MAX_PRESENT, NS_MIN_PRESENT, 4'h0, NS_ALLOC_WIDTH} : 32'h0))
    else $error("non-secure bandwidth partition fields misplaced");

  AST_S_MON_FIELDS: assert property (s_mon_feat == (S_MON_PRESENT ?
    {S_LOCAL_TRIG_PRESENT, 13'h0, S_BWU_MON_PRESENT, S_CACHE_MON_PRESENT, 16'h0} : 32'h0))
    else $error("secure monitoring fields misplaced");

  AST_NS_MON_FIELDS: assert property (ns_mon_feat == (NS_MON_PRESENT ?
    {NS_LOCAL_TRIG_PRESENT, 13'h0, NS_BWU_MON_PRESENT, NS_CACHE_MON_PRESENT, 16'h0} : 32'h0))
    else $error("non-secure monitoring fields misplaced");

  AST_S_BWU_FIELDS: assert property (s_bwu_mon == ((S_MON_PRESENT && S_BWU_MON_PRESENT) ?
    {S_SNAPSHOT_PRESENT, 10'h0, S_SCALE, S_MON_COUNT} : 32'h0))
    else $error("secure usage monitor fields misplaced");

  AST_NS_BWU_FIELDS: assert property (ns_bwu_mon == ((NS_MON_PRESENT && NS_BWU_MON_PRESENT) ?
    {NS_SNAPSHOT_PRESENT, 10'h0, NS_SCALE, NS_MON_COUNT} : 32'h0))
    else $error("non-secure usage monitor fields misplaced");

  // Remaining page and register combinations
  AST_S_MON_READ: assert property (s_read(1'b0, bwmid_pkg::BWMID_SEL_MON_FEAT) |=> rdata_o == s_mon_feat)
    else $error("secure monitoring read wrong");

  AST_S_BWU_READ: assert property (s_read(1'b0, bwmid_pkg::BWMID_SEL_BWU_MON) |=> rdata_o == s_bwu_mon)
    else $error("secure usage monitor read wrong");

  AST_NS_BW_READ: assert property (s_read(1'b1, bwmid_pkg::BWMID_SEL_BW_PART) |=> rdata_o == ns_bw_part)
    else $error("non-secure bandwidth partition read wrong");

  AST_NS_UNMAPPED_ZERO: assert property (s_read(1'b1, bwmid_pkg::BWMID_SEL_NONE) |=> ack_o && (rdata_o == 32'h0))
    else $error("non-secure unmapped read not zero");

  // Answer stands one cycle, outputs quiet otherwise
  AST_IDLE_QUIET: assert property (!ack_o |-> (rdata_o == 32'h0) && !wr_ignored_o)
    else $error("answer outputs active without answer strobe");

  AST_FLAG_WITH_ACK: assert property (wr_ignored_o |-> ack_o && (rdata_o == 32'h0))
    else $error("write flag without zero answer");

endmodule

// >>> bwmid_testbench.sv
// Self-checking bench of the bandwidth feature identification bank
`timescale 1ns/1ps
module testbench;
  // Clock, reset and access stimulus
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic wr_i = 1'b0;
  logic ns_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0000_0000;
  // Answers of the full bank and of the bank with absent registers
  logic ack_o;
  logic ack2_o;
  logic wr_ignored_o;
  logic wr_ignored2_o;
  logic [31:0] rdata_o;
  logic [31:0] rdata2_o;
  // Expected answer of one accepted access
  typedef struct packed {
    logic [31:0] rd;
    logic [31:0] rd2;
    logic wi;
  } bwmid_tb_note_s;
  bwmid_tb_note_s notes[$];
  bwmid_tb_note_s note;
  // Counters and random state
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] lfsr = 32'h0000_90db;
  // Register offsets and some holes around them
  logic [11:0] offs [3] = '{12'h040, 12'h080, 12'h090};
  logic [11:0] holes [5] = '{12'h000, 12'h041, 12'h044, 12'h08c, 12'hffc};
  // Words per bank and page: [bank*2+page][partition, monitoring, usage]
  // Bank 0 secure: width 1, stride and min, alloc 1; trigger and usage; snapshot, 4 monitors
  // Bank 0 non-secure: width 4096, window, portion, max, alloc 16; usage and cache; scale 31
  // Bank 1: secure page absent; non-secure defaults with usage monitoring absent
  localparam logic [31:0] EXP_W [4][3] = '{
    '{32'h0001_2401, 32'h8002_0000, 32'h8000_0004},
    '{32'h1000_5810, 32'h0003_0000, 32'h001f_ffff},
    '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
    '{32'h0020_3c08, 32'h8000_0000, 32'h0000_0000}};

  // Build values at the field boundaries
  localparam logic [12:0] PBM_NARROW = 13'h0001;
  localparam logic [12:0] PBM_WIDE = 13'h1000;
  localparam logic [5:0] ALLOC_NARROW = 6'h01;
  localparam logic [5:0] ALLOC_WIDE = 6'h10;
  localparam logic [4:0] SCALE_WIDE = 5'h1f;
  localparam logic [15:0] COUNT_WIDE = 16'hffff;
  localparam bit FLAG_ON = 1'b1;
  localparam bit FLAG_OFF = 1'b0;

  // Bank with differing pages at the field boundaries
  bwmid_feature_bank #(
    .S_PBM_WIDTH(PBM_NARROW), .S_PORTION_PRESENT(FLAG_OFF), .S_MAX_PRESENT(FLAG_OFF), .S_ALLOC_WIDTH(ALLOC_NARROW),
    .NS_PBM_WIDTH(PBM_WIDE), .NS_WIN_WRITABLE(FLAG_ON), .NS_STRIDE_PRESENT(FLAG_OFF), .NS_MIN_PRESENT(FLAG_OFF),
    .NS_ALLOC_WIDTH(ALLOC_WIDE), .NS_SNAPSHOT_PRESENT(FLAG_OFF), .NS_SCALE(SCALE_WIDE), .NS_MON_COUNT(COUNT_WIDE),
    .NS_LOCAL_TRIG_PRESENT(FLAG_OFF), .NS_CACHE_MON_PRESENT(FLAG_ON)
  ) dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i), .ns_i(ns_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .ack_o(ack_o), .rdata_o(rdata_o), .wr_ignored_o(wr_ignored_o)
  );
  // Bank whose secure page and non-secure usage register are absent by their presence flags
  bwmid_feature_bank #(
    .S_BW_PART_PRESENT(FLAG_OFF), .S_MON_PRESENT(FLAG_OFF), .NS_BWU_MON_PRESENT(FLAG_OFF)
  ) dut_absent (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i), .ns_i(ns_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .ack_o(ack2_o), .rdata_o(rdata2_o), .wr_ignored_o(wr_ignored2_o)
  );

  // Free-running clock
  always #4 clk_i = ~clk_i;

  // Next pseudo-random word
  function automatic logic [31:0] lfsr_next();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Word a read must return; holes read zero
  function automatic logic [31:0] expect_word(input int d, input logic n, input logic [11:0] a);
    int r;
    r = (a == 12'h040) ? 0 : (a == 12'h080) ? 1 : (a == 12'h090) ? 2 : 3;
    if (r == 3) begin
      return 32'h0000_0000;
    end
    return EXP_W[d * 2 + (n ? 1 : 0)][r];
  endfunction

  // Compare of 32-bit values
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare of single flags
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One access held for a number of cycles; writes expect a zero answer
  task automatic access(input logic w, input logic n, input logic [11:0] a, input int hold);
    bwmid_tb_note_s nt;
    nt.rd = w ? 32'h0000_0000 : expect_word(0, n, a);
    nt.rd2 = w ? 32'h0000_0000 : expect_word(1, n, a);
    nt.wi = w;
    wdata_i = lfsr_next();
    wr_i = w;
    ns_i = n;
    addr_i = a;
    notes.push_back(nt);
    req_i = 1'b1;
    repeat (hold) @(negedge clk_i);
    req_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  // Prints the counts and the verdict, then stops
  task automatic test_done();
    chk1("pending answers", 1'b1, notes.size() == 0);
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watches answers at each falling edge and retires the oldest note
  always @(negedge clk_i) begin
    if (rst_i) begin
      chk1("ack in reset", 1'b0, ack_o);
    end else if (ack_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk1("unexpected ack", 1'b0, ack_o);
      end else begin
        note = notes.pop_front();
        chk32("rdata", note.rd, rdata_o);
        chk32("rdata absent bank", note.rd2, rdata2_o);
        chk1("wr_ignored", note.wi, wr_ignored_o);
        chk1("wr_ignored absent bank", note.wi, wr_ignored2_o);
        chk1("ack absent bank", 1'b1, ack2_o);
      end
    end else begin
      chk1("idle ack", 1'b0, ack_o);
      chk1("idle ack absent bank", 1'b0, ack2_o);
      chk1("idle wr_ignored", 1'b0, wr_ignored_o);
      chk32("idle rdata absent bank", 32'h0000_0000, rdata2_o);
      chk32("idle rdata", 32'h0000_0000, rdata_o);
    end
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    logic [11:0] a;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    // Every register on both pages, a write to it, then a reread
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 3; r++) begin
        access(1'b0, p[0], offs[r], 1);
        access(1'b1, p[0], offs[r], 1);
        access(1'b0, p[0], offs[r], 1);
      end
    end
    // Unmapped places near and away from the registers read zero on both pages
    foreach (holes[i]) begin
      access(1'b0, 1'b0, holes[i], 1);
      access(1'b0, 1'b1, holes[i], 1);
    end
    // Request held two cycles: only one answer comes
    access(1'b0, 1'b1, 12'h090, 2);
    // Random reads and writes on random pages and addresses
    repeat (60) begin
      v = lfsr_next();
      a = v[3] ? v[15:4] : offs[int'(v[5:4]) % 3];
      access(v[0], v[1], a, 1);
    end
    // Second reset in mid-run, then a readback
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    access(1'b0, 1'b0, 12'h040, 1);
    test_done();
  end

  // Cuts a hang short well past the expected run length
  initial begin
    #(8 * 5000);
    miscompares++;
    test_done();
  end
endmodule
